// file: hw/oar_pkg.sv
// constants, field layouts and types shared by the overload restart block
// assumes a 20 MHz system clock and a classic wishbone master
package oar_pkg;

  // clock and tick base
  localparam int unsigned CLK_HZ   = 20_000_000;   // system clock rate
  localparam int unsigned TICK_US  = 1000;         // one timing tick, microseconds
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

  // durations in milliseconds, as the transmitter uses them
  localparam int unsigned DELAY_MS  = 500;         // wait before a restart pulse
  localparam int unsigned PULSE_MS  = 500;         // restart pulse length
  localparam int unsigned WINDOW_MS = 30000;       // attempt counting window
  localparam int unsigned FOLD_MS   = 10000;       // foldback hold-off after reflected trip
  localparam int unsigned PWRUP_MS  = 100;         // power-restored pulse length

  // the same durations in ticks
  localparam logic [15:0] DELAY_TK  = 16'(DELAY_MS * 1000 / TICK_US);
  localparam logic [15:0] PULSE_TK  = 16'(PULSE_MS * 1000 / TICK_US);
  localparam logic [15:0] WINDOW_TK = 16'(WINDOW_MS * 1000 / TICK_US);
  localparam logic [15:0] FOLD_TK   = 16'(FOLD_MS * 1000 / TICK_US);
  localparam logic [15:0] PWRUP_TK  = 16'(PWRUP_MS * 1000 / TICK_US);

  // restart limits selected by the strap
  localparam logic [2:0] LIM_TWO  = 3'h2;
  localparam logic [2:0] LIM_FOUR = 3'h4;

  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0;

  // control field positions
  localparam int unsigned CT_DIS  = 0;             // software restart disable, level
  localparam int unsigned CT_TEST = 1;             // software restart test, write one
  localparam int unsigned CT_CLR  = 2;             // software fault clear, write one

  // status field positions
  localparam int unsigned ST_FLT   = 0;            // three fault flags
  localparam int unsigned ST_LOCK  = 3;
  localparam int unsigned ST_ACT   = 4;
  localparam int unsigned ST_CNT   = 5;            // three-bit attempt count
  localparam int unsigned ST_AUTO  = 8;
  localparam int unsigned ST_PLATE = 9;
  localparam int unsigned ST_FOLD  = 10;
  localparam int unsigned ST_FOUR  = 11;

  // pin inputs from the transmitter, all asynchronous
  localparam int unsigned NPINS = 14;
  typedef struct packed {
    logic plate_ovl;     // plate overload pulse
    logic screen_ovl;    // screen overload pulse
    logic refl_ovl;      // reflected power overload pulse
    logic fault_clr;     // panel fault clear switch
    logic rst_dis;       // restart disable switch
    logic rst_test;      // restart test switch
    logic mains_ok;      // primary power present
    logic auto_cmd;      // select automatic level control
    logic man_cmd;       // select manual level control
    logic lower_cmd;     // remote lower
    logic raise_cmd;     // remote raise
    logic supply_ok;     // control supply present
    logic level2_req;    // second power level request
    logic limit_four;    // strap: four attempts instead of two
  } oar_pins_t;

  // restart sequencer states
  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b001,
    SQ_WAIT  = 3'b010,
    SQ_PULSE = 3'b100
  } oar_seq_t;

endpackage

// file: hw/oar_sync.sv
// three-flop input synchroniser with agreement filter for all pins
// assumes pins are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module oar_sync
  import oar_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [NPINS-1:0] raw_i,
  output var  logic [NPINS-1:0] level_o
);

  logic [NPINS-1:0] s1_q;   // metastable stage, read only by s2
  logic [NPINS-1:0] s2_q;
  logic [NPINS-1:0] s3_q;

  ////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_bit
      // a change counts only once stages two and three agree
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[i]    <= 1'b0;
          s2_q[i]    <= 1'b0;
          s3_q[i]    <= 1'b0;
          level_o[i] <= 1'b0;
        end else begin
          s1_q[i] <= raw_i[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            level_o[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// file: hw/oar_tick.sv
// tick prescaler: one-cycle pulse every CYC clocks
// assumes CYC of at least one
`timescale 1ns/100ps
`default_nettype none
module oar_tick
  import oar_pkg::*;
#(
  parameter int unsigned CYC = TICK_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output var  logic tick_o
);

  logic [31:0] cnt_q;   // cycles into the current tick

  // free-running divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == 32'(CYC - 1)) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: hw/oar_top.sv
// overload memory and automatic restart controller with wishbone registers
// assumes asynchronous panel and relay pins, one 20 MHz clock, sync reset
`timescale 1ns/100ps
`default_nettype none
// Contract
// - each overload sets its own flag and lamp
// - flags hold until fault clear is pressed
// - any overload drops plate power enable
// - overload also triggers restart in same cycle
// - default limit two restarts per window
// - strap selects limit two or four
// - wait half second, then half second pulse
// - restart pulse asserts plate-on request
// - restart lamp lit during pulse
// - count attempts, block at the limit
// - lockout lamp lit while blocked
// - window expiry clears count and lockout
// - expiry below limit also clears count
// - disable input suppresses all restarts
// - test input triggers restart without fault flag
// - mains return gives brief plate-on pulse
// - latched auto/manual selection with two lamps
// - raise and lower drive motor while held
// - control supply loss removes plate power
// - reflected trip holds off foldback ten seconds
module oar_top
  import oar_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC   // shorten for simulation
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire oar_pins_t   pins_i,
  output var  logic        plate_trip_lamp_o,
  output var  logic        screen_trip_lamp_o,
  output var  logic        reflected_trip_lamp_o,
  output var  logic        plate_enable_o,
  output var  logic        plate_on_req_o,
  output var  logic        restart_active_lamp_o,
  output var  logic        restart_blocked_lamp_o,
  output var  logic        automatic_level_lamp_o,
  output var  logic        manual_level_lamp_o,
  output var  logic        motor_lower_o,
  output var  logic        motor_raise_o,
  output var  logic        second_level_o,
  output var  logic        foldback_inhibit_o
);
  ////////////////////////////////////////////////////////////////////////
  // synchronised pins and timing tick
  oar_pins_t   lvl;          // filtered pin levels
  oar_pins_t   prev_q;       // levels one cycle ago, for edges
  logic        tick;         // one pulse per timing tick
  oar_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (pins_i),
    .level_o (lvl)
  );
  oar_tick #(
    .CYC (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );
  // remember last levels so each pin change is seen once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= lvl;
    end
  end
  logic [2:0]  ovl_lvl;      // overload levels plate, screen, reflected
  logic [2:0]  ovl_rise;     // overload onsets
  logic        test_rise;    // restart test switch onset
  logic        mains_rise;   // primary power returned
  logic        auto_rise;    // automatic selection pulse
  logic        man_rise;     // manual selection pulse
  assign ovl_lvl    = {lvl.refl_ovl, lvl.screen_ovl, lvl.plate_ovl};
  assign ovl_rise   = ovl_lvl & ~{prev_q.refl_ovl, prev_q.screen_ovl, prev_q.plate_ovl};
  assign test_rise  = lvl.rst_test & ~prev_q.rst_test;
  assign mains_rise = lvl.mains_ok & ~prev_q.mains_ok;
  assign auto_rise  = lvl.auto_cmd & ~prev_q.auto_cmd;
  assign man_rise   = lvl.man_cmd & ~prev_q.man_cmd;
  ////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state, unmapped reads return zero
  logic        sw_dis_q;     // software restart disable
  logic        sw_test_q;    // software test, one-cycle pulse
  logic        sw_clr_q;     // software fault clear, one-cycle pulse
  logic        wb_req;       // fresh request this cycle
  logic        wb_wr;        // fresh write to the control register
  logic [31:0] stat;         // live status word
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);
  // ack for one cycle; the ~ack term keeps a held request from double-acking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end
  // control register; test and clear self-clear after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_dis_q  <= CTRL_RST[CT_DIS];
      sw_test_q <= CTRL_RST[CT_TEST];
      sw_clr_q  <= CTRL_RST[CT_CLR];
    end else begin
      sw_test_q <= wb_wr & wb_dat_i[CT_TEST];
      sw_clr_q  <= wb_wr & wb_dat_i[CT_CLR];
      if (wb_wr) begin
        sw_dis_q <= wb_dat_i[CT_DIS];
      end
    end
  end
  // read data latched with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req & ~wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= {31'h0, sw_dis_q};
        ADR_STAT: wb_dat_o <= stat;
        default:  wb_dat_o <= 32'h0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // fault memory
  logic [2:0]  flt_q;        // plate, screen, reflected sticky flags
  logic        fault_clr;    // panel or software clear
  assign fault_clr = lvl.fault_clr | sw_clr_q;
  // a new overload wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_q <= 3'h0;
    end else begin
      flt_q <= (flt_q & ~{3{fault_clr}}) | ovl_rise;
    end
  end
  assign plate_trip_lamp_o     = flt_q[0];
  assign screen_trip_lamp_o    = flt_q[1];
  assign reflected_trip_lamp_o = flt_q[2];
  ////////////////////////////////////////////////////////////////////////
  // restart sequencer
  oar_seq_t    seq_q;        // sequencer state
  logic [15:0] seq_tmr_q;    // ticks left in wait or pulse
  logic [2:0]  cnt_q;        // restart attempts in the window
  logic [2:0]  limit;        // attempts allowed in a window
  logic        lockout;      // limit reached
  logic        disabled;     // pin or software disable
  logic        trig;         // restart trigger
  logic        accept;       // trigger taken by the sequencer
  logic        seq_done;     // wait or pulse timer runs out
  logic        start_pulse;  // a restart pulse begins
  // the strap is static, so its filtered level is used as it stands
  assign limit    = lvl.limit_four ? LIM_FOUR : LIM_TWO;
  assign lockout  = (cnt_q >= limit);
  assign disabled = lvl.rst_dis | sw_dis_q;
  // overload onsets feed the sequencer directly; test bypasses the flags
  assign trig     = (|ovl_rise) | test_rise | sw_test_q;
  assign accept   = (seq_q == SQ_IDLE) & trig & ~disabled & ~lockout;
  assign seq_done = tick & (seq_tmr_q == 16'h1);
  // a pulse started while already locked or disabled is dropped
  assign start_pulse = (seq_q == SQ_WAIT) & seq_done & ~lockout & ~disabled;
  // triggers during a running wait or pulse are absorbed, one sequence at a time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q     <= SQ_IDLE;
      seq_tmr_q <= 16'h0;
    end else begin
      case (seq_q)
        SQ_IDLE: begin
          if (accept) begin
            seq_q     <= SQ_WAIT;
            seq_tmr_q <= DELAY_TK;
          end
        end
        SQ_WAIT: begin
          if (disabled) begin
            seq_q <= SQ_IDLE;
          end else if (seq_done) begin
            seq_q     <= lockout ? SQ_IDLE : SQ_PULSE;
            seq_tmr_q <= PULSE_TK;
          end else if (tick) begin
            seq_tmr_q <= seq_tmr_q - 16'h1;
          end
        end
        SQ_PULSE: begin
          if (seq_done | disabled) begin
            seq_q <= SQ_IDLE;
          end else if (tick) begin
            seq_tmr_q <= seq_tmr_q - 16'h1;
          end
        end
        default: begin
          seq_q <= SQ_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // attempt window and counter
  logic        win_q;        // window running
  logic [15:0] win_tmr_q;    // ticks left in the window
  logic        win_end;      // window expires this cycle
  assign win_end = win_q & tick & (win_tmr_q == 16'h1);
  // expiry clears the count; a pulse in the same cycle opens a fresh window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q     <= 1'b0;
      win_tmr_q <= 16'h0;
      cnt_q     <= 3'h0;
    end else begin
      if (win_end) begin
        cnt_q <= start_pulse ? 3'h1 : 3'h0;
        win_q <= start_pulse;
        win_tmr_q <= WINDOW_TK;
      end else begin
        if (start_pulse) begin
          cnt_q <= cnt_q + 3'h1;
        end
        if (~win_q & ((accept & (cnt_q == 3'h0)) | start_pulse)) begin
          win_q     <= 1'b1;
          win_tmr_q <= WINDOW_TK;
        end else if (win_q & tick) begin
          win_tmr_q <= win_tmr_q - 16'h1;
        end
      end
    end
  end
  assign restart_active_lamp_o = seq_q[2];
  logic        lock_lamp_q;  // lockout lamp
  // lamp follows the counter one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_lamp_q <= 1'b0;
    end else begin
      lock_lamp_q <= lockout;
    end
  end
  assign restart_blocked_lamp_o = lock_lamp_q;
  ////////////////////////////////////////////////////////////////////////
  // power-restored pulse
  logic        pwr_q;        // power-restored pulse running
  logic [15:0] pwr_tmr_q;    // ticks left in it
  // brief plate-on request after mains comes back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q     <= 1'b0;
      pwr_tmr_q <= 16'h0;
    end else if (mains_rise) begin
      pwr_q     <= 1'b1;
      pwr_tmr_q <= PWRUP_TK;
    end else if (pwr_q & tick) begin
      pwr_tmr_q <= pwr_tmr_q - 16'h1;
      if (pwr_tmr_q == 16'h1) begin
        pwr_q <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // plate control
  logic        req_q;        // plate-on request toward the relays
  logic        plate_q;      // plate power enable
  // restart pulse and power return both act like the plate-on switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
    end else begin
      req_q <= seq_q[2] | pwr_q;
    end
  end
  // an overload or a missing control supply beats any plate-on request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plate_q <= 1'b0;
    end else if ((|ovl_lvl) | ~lvl.supply_ok) begin
      plate_q <= 1'b0;
    end else if (req_q) begin
      plate_q <= 1'b1;
    end
  end
  assign plate_on_req_o = req_q;
  assign plate_enable_o = plate_q;
  ////////////////////////////////////////////////////////////////////////
  // level control selection, motor drive, second level
  logic        auto_q;       // automatic level selected
  logic        man_q;        // manual level selected
  logic        lower_q;      // motor toward lower power
  logic        raise_q;      // motor toward higher power
  logic        lvl2_q;       // second power level relay
  // bistable selection; manual after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_q <= 1'b0;
      man_q  <= 1'b1;
    end else if (auto_rise) begin
      auto_q <= 1'b1;
      man_q  <= 1'b0;
    end else if (man_rise) begin
      auto_q <= 1'b0;
      man_q  <= 1'b1;
    end
  end
  // conflicting raise and lower stop the motor rather than fight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lower_q <= 1'b0;
      raise_q <= 1'b0;
      lvl2_q  <= 1'b0;
    end else begin
      lower_q <= lvl.lower_cmd & ~lvl.raise_cmd;
      raise_q <= lvl.raise_cmd & ~lvl.lower_cmd;
      lvl2_q  <= lvl.level2_req;
    end
  end
  assign automatic_level_lamp_o = auto_q;
  assign manual_level_lamp_o    = man_q;
  assign motor_lower_o          = lower_q;
  assign motor_raise_o          = raise_q;
  assign second_level_o         = lvl2_q;
  ////////////////////////////////////////////////////////////////////////
  // foldback hold-off after a reflected trip
  logic        fold_q;       // foldback inhibited
  logic [15:0] fold_tmr_q;   // ticks left
  // full-power sampling of reflected power after restart needs foldback off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fold_q     <= 1'b0;
      fold_tmr_q <= 16'h0;
    end else if (ovl_rise[2]) begin
      fold_q     <= 1'b1;
      fold_tmr_q <= FOLD_TK;
    end else if (fold_q & tick) begin
      fold_tmr_q <= fold_tmr_q - 16'h1;
      if (fold_tmr_q == 16'h1) begin
        fold_q <= 1'b0;
      end
    end
  end
  assign foldback_inhibit_o = fold_q;
  ////////////////////////////////////////////////////////////////////////
  // status word, rebuilt every cycle from the live state
  always_comb begin
    stat                      = 32'h0;
    stat[ST_FLT +: 3]         = flt_q;
    stat[ST_LOCK]             = lockout;
    stat[ST_ACT]              = seq_q[2];
    stat[ST_CNT +: 3]         = cnt_q;
    stat[ST_AUTO]             = auto_q;
    stat[ST_PLATE]            = plate_q;
    stat[ST_FOLD]             = fold_q;
    stat[ST_FOUR]             = lvl.limit_four;
  end
endmodule
`default_nettype wire

// file: tb/oar_partner.sv
// far-side model: panel switches, remote inputs and overload relays
// assumes the bench sets switch levels and fires overloads on clk edges
`timescale 1ns/100ps
`default_nettype none
module oar_partner
  import oar_pkg::*;
(
  input  wire logic       clk_i,
  input  wire oar_pins_t  lvl_i,
  input  wire logic [3:0] fire_i,
  output var  oar_pins_t  pins_o
);
  logic [3:0] hit_q = '0;  // plate, screen, reflected, test
  logic [2:0] len_q = '0;  // pulse cycles left
  // relay pulses stretched so the input filter sees them
  always_ff @(posedge clk_i) begin
    if (|fire_i) begin
      hit_q <= fire_i;
      len_q <= 3'h6;
    end else if (len_q != 3'h0) len_q <= len_q - 3'h1;
    else hit_q <= '0;
  end
  always_comb begin
    pins_o = lvl_i;  // operator and remote levels
    pins_o.plate_ovl = hit_q[3];
    pins_o.screen_ovl = hit_q[2];
    pins_o.refl_ovl = hit_q[1];
    pins_o.rst_test = hit_q[0] | lvl_i.rst_test;
  end
endmodule
`default_nettype wire

// file: tb/oar_props.sv
// checker bound to the restart controller top
// assumes the top's port names and one clock domain
`timescale 1ns/100ps
`default_nettype none
module oar_checker
  import oar_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire oar_pins_t   pins_i,
  input wire logic        plate_trip_lamp_o,
  input wire logic        plate_enable_o,
  input wire logic        plate_on_req_o,
  input wire logic        restart_active_lamp_o,
  input wire logic        restart_blocked_lamp_o,
  input wire logic        automatic_level_lamp_o,
  input wire logic        manual_level_lamp_o,
  input wire logic        motor_lower_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0]  clr_q;  // cycles since a clear request
  logic [31:0] len_q;  // cycles of restart pulse so far
  localparam int unsigned PLEN = PULSE_TK * TICK_CYCLES;
  // clear age saturates so old clears never excuse a drop
  always_ff @(posedge clk_i) begin
    if (rst_i || pins_i.fault_clr || (wb_cyc_i && wb_stb_i && wb_we_i
        && wb_adr_i == ADR_CTRL && wb_dat_i[CT_CLR])) clr_q <= 4'h0;
    else if (clr_q != 4'hF) clr_q <= clr_q + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !restart_active_lamp_o) len_q <= 32'h0;
    else len_q <= len_q + 32'h1;
  end
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  flag_sticky_a: assert property ($fell(plate_trip_lamp_o) |-> clr_q < 4'h8)
    else $error("fault flag dropped without clear");
  trip_drops_a: assert property ($rose(plate_trip_lamp_o) |-> ##[0:1] !plate_enable_o)
    else $error("plate power kept on overload");
  restart_req_a: assert property ($rose(restart_active_lamp_o) |=> plate_on_req_o)
    else $error("restart pulse without plate-on");
  pulse_len_a: assert property ($fell(restart_active_lamp_o) && !pins_i.rst_dis
    |-> len_q + TICK_CYCLES + 1 >= PLEN && len_q <= PLEN + 1)
    else $error("restart pulse length wrong");
  no_restart_a: assert property (restart_blocked_lamp_o |-> !$rose(restart_active_lamp_o))
    else $error("restart while blocked");
  lamp_pair_a: assert property (automatic_level_lamp_o != manual_level_lamp_o)
    else $error("level lamps not exclusive");
  motor_lower_a: assert property ((pins_i.lower_cmd && !pins_i.raise_cmd) [*6] |=> motor_lower_o)
    else $error("motor not lowering");
  failsafe_a: assert property (!pins_i.supply_ok [*6] |=> !plate_enable_o)
    else $error("plate power kept without supply");
endmodule
bind oar_top oar_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
`default_nettype wire

// file: tb/test_overload_auto_recycle.sv
// self-checking bench for the overload restart controller
// assumes a tick of two clocks so half a second is 1000 cycles
`timescale 1ns/100ps
`default_nettype none
module test_overload_auto_recycle;
  import oar_pkg::*;
  localparam int ACT = 5, PE = 3, BLK = 6;  // output vector indices
  logic clk = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, dout, rdat;
  logic [3:0] fire = '0;
  logic [12:0] o;  // lamps and relay outputs
  oar_pins_t lvl = '0, pins;
  int err_count = 0, checks = 0, n;
  always #25 clk = ~clk;
  oar_partner pm (.clk_i(clk), .lvl_i(lvl), .fire_i(fire), .pins_o(pins));
  oar_top #(.TICK_CYCLES(2)) dut (.clk_i(clk), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .pins_i(pins), .plate_trip_lamp_o(o[0]), .screen_trip_lamp_o(o[1]),
    .reflected_trip_lamp_o(o[2]), .plate_enable_o(o[3]), .plate_on_req_o(o[4]),
    .restart_active_lamp_o(o[5]), .restart_blocked_lamp_o(o[6]),
    .automatic_level_lamp_o(o[7]), .manual_level_lamp_o(o[8]), .motor_lower_o(o[9]),
    .motor_raise_o(o[10]), .second_level_o(o[11]), .foldback_inhibit_o(o[12]));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) chk(0, 1);
    rdat = dout;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic wfor(input int i, input logic v, input int lim, output int c);
    c = 0;
    while (o[i] !== v && c < lim) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic hit(input logic [3:0] f);
    fire <= f;
    @(posedge clk);
    fire <= '0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    lvl.mains_ok <= 1;
    lvl.supply_ok <= 1;
    repeat (10) @(posedge clk);
    rst_i <= 0;
    wb(0, ADR_CTRL, 0);
    chk(rdat, CTRL_RST);
    wb(0, 8'h08, 0);
    chk(rdat, 0);
    chk(o[8:7], 2'b10);
    lvl.auto_cmd <= 1;
    repeat (8) @(posedge clk);
    lvl.auto_cmd <= 0;
    lvl.lower_cmd <= 1;
    repeat (8) @(posedge clk);
    chk(o[8:7], 2'b01);
    chk(o[10:9], 2'b01);
    lvl.lower_cmd <= 0;
    lvl.raise_cmd <= 1;
    lvl.level2_req <= 1;
    repeat (8) @(posedge clk);
    chk(o[10:9], 2'b10);
    chk(o[11], 1);
    lvl.raise_cmd <= 0;
    lvl.level2_req <= 0;
    wfor(PE, 1, 400, n);
    chk(o[PE], 1);
    // plate trip: flag, power off, delayed restart pulse
    hit(4'h8);
    repeat (10) @(posedge clk);
    chk(o[3:0], 4'b0001);
    chk(o[11], 0);
    wfor(ACT, 1, 1100, n);
    chk(32'(n >= 985 && n <= 1002), 1);
    @(posedge clk);
    chk(o[4], 1);
    wfor(ACT, 0, 1100, n);
    chk(32'(n >= 995 && n <= 1002), 1);
    hit(4'h4);
    repeat (10) @(posedge clk);
    chk(o[2:0], 3'b011);
    wfor(ACT, 1, 1100, n);
    wfor(ACT, 0, 1100, n);
    chk(o[BLK], 1);
    wb(0, ADR_STAT, 0);
    chk(rdat[ST_CNT+:3], 2);
    hit(4'h2);
    repeat (10) @(posedge clk);
    chk(o[2:0], 3'b111);
    chk(o[12], 1);
    wfor(ACT, 1, 1200, n);
    chk(n, 1200);
    lvl.fault_clr <= 1;
    repeat (8) @(posedge clk);
    lvl.fault_clr <= 0;
    repeat (2) @(posedge clk);
    chk(o[2:0], 0);
    wfor(BLK, 0, 62000, n);
    wb(0, ADR_STAT, 0);
    chk(rdat[ST_CNT+:3], 0);
    wb(1, ADR_CTRL, 32'h1);
    hit(4'h1);
    wfor(ACT, 1, 1200, n);
    chk(n, 1200);
    wb(1, ADR_CTRL, 0);
    lvl.limit_four <= 1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      chk(o[BLK], 0);
      if (i == 0) wb(1, ADR_CTRL, 32'h1 << CT_TEST);
      else hit(4'h1);
      wfor(ACT, 1, 1200, n);
      chk(32'(n < 1200), 1);
      wfor(ACT, 0, 1200, n);
    end
    chk(o[BLK], 1);
    chk(o[2:0], 0);
    lvl.supply_ok <= 0;
    repeat (8) @(posedge clk);
    chk(o[PE], 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
